// ---- inc/smcm_pkg.sv ----
package smcm_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int ADDR_W        = 17;
	localparam int MEM_WORDS     = 32768;

	// board offsets, equal to the AHB byte addresses
	localparam logic [16:0] BUS_STAT_OFS = 17'h00000;
	localparam logic [16:0] STAT_WIN_HI  = 17'h00fff;
	localparam logic [16:0] BI_CTL_OFS   = 17'h00010;
	localparam logic [16:0] BI_VEC_OFS   = 17'h00020;
	localparam logic [16:0] LRST_LO      = 17'h01800;
	localparam logic [16:0] LRST_HI      = 17'h01fff;
	localparam logic [16:0] DPR_LO       = 17'h02000;
	localparam logic [16:0] REV_OFS      = 17'h02000;
	localparam logic [16:0] TMSG_OFS     = 17'h020f0;
	localparam logic [16:0] BLK1_OFS     = 17'h02100;
	localparam logic [16:0] CHAIN1_OFS   = 17'h02110;
	localparam logic [16:0] IOBUF1_OFS   = 17'h02300;
	localparam logic [16:0] IOBUF2_OFS   = 17'h02b00;
	localparam logic [16:0] CHAIN2_OFS   = 17'h03300;
	localparam logic [16:0] BLK2_OFS     = 17'h03500;
	localparam logic [16:0] HASH_LO      = 17'h04000;
	localparam int          HASH_BUFS    = 16;
	localparam int          HASH_BUF_B   = 7168;

	localparam logic [14:0] BLK1_IDX   = BLK1_OFS[16:2];
	localparam logic [14:0] BLK2_IDX   = BLK2_OFS[16:2];
	localparam logic [14:0] CHAIN1_IDX = CHAIN1_OFS[16:2];
	localparam logic [14:0] CHAIN2_IDX = CHAIN2_OFS[16:2];
	localparam logic [14:0] BLK_WORDS  = 15'h0004;

	// command word fields
	localparam int CMD_DONE_BIT = 15;
	localparam int CMD_IE_BIT   = 12;
	localparam int TID_HI       = 11;
	localparam int TID_LO       = 9;
	localparam int GRP_HI       = 7;
	localparam int GRP_LO       = 4;
	localparam logic [3:0] GRP_LAST = 4'h6;

	// bus-side status word and interrupter control
	localparam int STAT_RST_BIT  = 8;
	localparam int STAT_FAIL_BIT = 9;
	localparam int STAT_BUSY_BIT = 10;
	localparam int BI_EN_BIT     = 4;

	localparam logic [11:0] ERR_NONE    = 12'h000;
	localparam logic [11:0] ERR_INVALID = 12'h006;
	localparam logic [11:0] ERR_CHAIN   = 12'h010;

	localparam int RESET_TIME_NS = 1000;
	localparam logic [7:0] RESET_CYC = 8'((RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam logic [7:0] OP_SET_OFFS  = 8'h03;
	localparam logic [7:0] OP_FW_RESET  = 8'h09;
	localparam logic [7:0] OP_INST_UNIT = 8'h0a;
	localparam logic [7:0] OP_MAIN_INIT = 8'h0d;
	localparam logic [7:0] OP_AUTOFLUSH = 8'h0e;
	localparam logic [7:0] OP_BYTE_RD   = 8'h10;
	localparam logic [7:0] OP_BYTE_WR   = 8'h14;
	localparam logic [7:0] OP_BLOCK_RD  = 8'h20;
	localparam logic [7:0] OP_BLOCK_WR  = 8'h22;
	localparam logic [7:0] OP_DELIM_RD  = 8'h30;
	localparam logic [7:0] OP_DELIM_WR  = 8'h32;
	localparam logic [7:0] OP_COUNT_RD  = 8'h33;
	localparam logic [7:0] OP_COUNT_WR  = 8'h35;
	localparam logic [7:0] OP_CTL_STAT  = 8'h44;
	localparam logic [7:0] OP_UNIT_PARM = 8'h46;
	localparam logic [7:0] OP_RUN_PROG  = 8'h50;
	localparam logic [7:0] OP_SPEC_LO   = 8'h55;
	localparam logic [7:0] OP_CHAIN     = 8'h5d;
	localparam logic [7:0] OP_SPEC_HI   = 8'h5e;
	localparam logic [7:0] OP_PASSTHRU  = 8'h60;
	localparam logic [7:0] OP_TMODE     = 8'h61;
	localparam logic [7:0] OP_TMSG_IRQ  = 8'h63;

	typedef enum logic [2:0] {
		ST_RESET   = 3'b000,
		ST_POLL    = 3'b001,
		ST_EXEC    = 3'b010,
		ST_ROOT    = 3'b011,
		ST_ROOTPTR = 3'b100
	} smcm_state_e;

	function automatic logic [15:0] mk_status(input logic ie, input logic [11:0] code);
		return {1'b1, 2'b00, ie, code};
	endfunction
endpackage

// ---- src/smcm_cmd_decode.sv ----
`timescale 1ns/1ps
module smcm_cmd_decode (
	input  wire logic [15:0] i_cmd,
	output logic             o_known,
	output logic             o_irq_en,
	output logic [2:0]       o_target,
	output logic             o_is_reset,
	output logic             o_is_chain,
	output logic             o_is_tmode,
	output logic             o_is_tirq
);
	wire [7:0] op  = i_cmd[smcm_pkg::GRP_HI:0];
	wire [3:0] grp = i_cmd[smcm_pkg::GRP_HI:smcm_pkg::GRP_LO];

	// bits 14..13 reserved and bit 8 don't care: neither reaches the decode
	wire grp_ok = (grp <= smcm_pkg::GRP_LAST);
	wire init_op = (op == smcm_pkg::OP_SET_OFFS) || (op == smcm_pkg::OP_FW_RESET)
		|| ((op >= smcm_pkg::OP_INST_UNIT) && (op <= smcm_pkg::OP_AUTOFLUSH));
	wire xfer_op = (op == smcm_pkg::OP_BYTE_RD) || (op == smcm_pkg::OP_BYTE_WR)
		|| (op == smcm_pkg::OP_BLOCK_RD) || (op == smcm_pkg::OP_BLOCK_WR)
		|| (op == smcm_pkg::OP_DELIM_RD) || (op == smcm_pkg::OP_DELIM_WR)
		|| (op == smcm_pkg::OP_COUNT_RD) || (op == smcm_pkg::OP_COUNT_WR);
	wire stat_op = ((op >= smcm_pkg::OP_CTL_STAT) && (op <= smcm_pkg::OP_UNIT_PARM))
		|| (op == smcm_pkg::OP_RUN_PROG)
		|| ((op >= smcm_pkg::OP_SPEC_LO) && (op <= smcm_pkg::OP_SPEC_HI));
	wire bus_op  = (op == smcm_pkg::OP_PASSTHRU) || (op == smcm_pkg::OP_TMODE)
		|| (op == smcm_pkg::OP_TMSG_IRQ);

	assign o_known    = grp_ok && (init_op || xfer_op || stat_op || bus_op);
	assign o_irq_en   = i_cmd[smcm_pkg::CMD_IE_BIT];
	assign o_target   = i_cmd[smcm_pkg::TID_HI:smcm_pkg::TID_LO];
	assign o_is_reset = (op == smcm_pkg::OP_FW_RESET);
	assign o_is_chain = (op == smcm_pkg::OP_CHAIN);
	assign o_is_tmode = (op == smcm_pkg::OP_TMODE);
	assign o_is_tirq  = (op == smcm_pkg::OP_TMSG_IRQ);
endmodule

// ---- src/smcm_mailbox.sv ----
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - two 16-byte command blocks, one per channel
// - bit 15 set marks status replacing command
// - bit 12 requests completion interrupt, two vectors
// - bits 11..9 carry target id
// - bits 14..13 reserved, bit 8 ignored
// - bits 7..4 group, 3..0 command
// - status at 0, data at 2, pointer at 4
// - zero long word ends chain, single mode again
// - per-block status; root gets error and pointer
// - chain interrupts per command and at end
// - revision word at board offset 0x2000
// - target message area at 0x20f0
// - first window read returns reset/failure status
// - interrupter control and vector registers in window
// - access in reset window resets the controller
// - chain areas and I/O buffers in shared memory
// - 0x4000..0x1ffff are sixteen 7 KB caching buffers
// - initialization opcode set
// - data transfer opcode set
// - status and special opcode set
// - storage-bus specific opcode set
module smcm_mailbox #(
	parameter logic [15:0] REVISION = 16'h0100 // arbitrary coded value
) (
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	input  wire logic        i_tgt_msg_valid,
	input  wire logic [2:0]  i_tgt_initiator,
	input  wire logic [31:0] i_tgt_data_ptr,
	input  wire logic [15:0] i_tgt_blocks,
	output logic             o_irq,
	output logic      [7:0]  o_irq_vector,
	output logic             o_sysfail,
	output logic             o_target_mode
);
	logic [31:0]            dpr_mem [0:smcm_pkg::MEM_WORDS-1];
	smcm_pkg::smcm_state_e  state_reg, state_next;
	logic                   chan_reg, chan_next, chain_reg, chain_next, cerr_reg, cerr_next;
	logic                   rie_reg, rie_next, tmode_reg, tmode_next, tirq_reg, tirq_next;
	logic [14:0]            cur_reg, cur_next, root_reg, root_next, fail_reg, fail_next;
	logic [7:0]             cnt_reg, cnt_next, vec_reg, vec_next;
	logic                   irq_reg, irq_next, rst_src_reg, sysfail_reg;
	logic                   dph_valid_reg, dph_write_reg, hready_reg;
	logic [16:0]            dph_addr_reg;
	logic [31:0]            hrdata_reg, stat_word;
	logic [7:0]             bi_ctl_reg [0:3];
	logic [7:0]             bi_vec_reg [0:3];
	logic                   tmsg_flag_reg;
	logic [2:0]             tmsg_init_reg;
	logic [31:0]            tmsg_ptr_reg;
	logic [15:0]            tmsg_blk_reg;
	logic                   eng_we;
	logic [14:0]            eng_wa;
	logic [31:0]            eng_wd;
	logic                   dec_known, dec_ie, dec_reset, dec_chain, dec_tmode, dec_tirq;

	// ---- AHB-Lite decode ----
	wire        addr_acc = i_hsel && i_htrans[1] && i_hready;
	wire [16:0] a        = dph_addr_reg;
	wire [14:0] dph_idx  = a[16:2];
	wire        is_rev   = (dph_idx == smcm_pkg::REV_OFS[16:2]);
	wire        is_tmsg0 = (dph_idx == smcm_pkg::TMSG_OFS[16:2]);
	wire        is_tmsg1 = (dph_idx == smcm_pkg::TMSG_OFS[16:2] + 15'h0001);
	wire        is_tmsg2 = (dph_idx == smcm_pkg::TMSG_OFS[16:2] + 15'h0002);
	wire        in_dpr   = (a >= smcm_pkg::DPR_LO);
	wire        is_bictl = (a[16:4] == smcm_pkg::BI_CTL_OFS[16:4]);
	wire        is_bivec = (a[16:4] == smcm_pkg::BI_VEC_OFS[16:4]);
	wire        is_stat  = (a <= smcm_pkg::STAT_WIN_HI) && !is_bictl && !is_bivec;
	wire        is_lrst  = (a >= smcm_pkg::LRST_LO) && (a <= smcm_pkg::LRST_HI);
	wire        dph_wr   = dph_valid_reg && dph_write_reg;
	wire        lrst_hit = dph_valid_reg && is_lrst;
	wire        ahb_mem_wr = dph_wr && in_dpr && !is_rev && !is_tmsg0 && !is_tmsg1 && !is_tmsg2;
	wire        rd_done  = dph_valid_reg && !dph_write_reg;

	wire [31:0] rd_data =
		is_rev   ? {16'h0000, REVISION} :
		is_tmsg0 ? {13'h0000, tmsg_init_reg, tmsg_flag_reg, 15'h0000} :
		is_tmsg1 ? tmsg_ptr_reg :
		is_tmsg2 ? {16'h0000, tmsg_blk_reg} :
		in_dpr   ? dpr_mem[dph_idx] :
		is_bictl ? {24'h000000, bi_ctl_reg[a[3:2]]} :
		is_bivec ? {24'h000000, bi_vec_reg[a[3:2]]} :
		is_stat  ? stat_word : 32'h00000000;

	always_comb begin
		stat_word = 32'h00000000;
		stat_word[smcm_pkg::STAT_RST_BIT]  = rst_src_reg;
		stat_word[smcm_pkg::STAT_FAIL_BIT] = sysfail_reg;
		stat_word[smcm_pkg::STAT_BUSY_BIT] = (state_reg != smcm_pkg::ST_POLL);
	end

	// ---- command engine ----
	wire [14:0] poll_idx  = chan_reg ? smcm_pkg::BLK2_IDX : smcm_pkg::BLK1_IDX;
	wire [15:0] poll_word = dpr_mem[poll_idx][15:0];
	wire [31:0] cur_word  = dpr_mem[cur_reg];
	wire        eng_ok    = eng_we && !ahb_mem_wr;
	wire        cmd_err   = !dec_known || (chain_reg && dec_chain);
	wire        mem_we    = ahb_mem_wr || eng_we;
	wire [14:0] mem_wa    = ahb_mem_wr ? dph_idx : eng_wa;
	wire [31:0] mem_wd    = ahb_mem_wr ? i_hwdata : eng_wd;
	wire        tgt_irq   = tmode_reg && tirq_reg && i_tgt_msg_valid && bi_ctl_reg[0][smcm_pkg::BI_EN_BIT];

	smcm_cmd_decode u_decode (
		.i_cmd      (cur_word[15:0]),
		.o_known    (dec_known),
		.o_irq_en   (dec_ie),
		.o_target   (),
		.o_is_reset (dec_reset),
		.o_is_chain (dec_chain),
		.o_is_tmode (dec_tmode),
		.o_is_tirq  (dec_tirq)
	);

	always_comb begin
		state_next = state_reg;
		chan_next  = chan_reg;
		cur_next   = cur_reg;
		root_next  = root_reg;
		chain_next = chain_reg;
		cerr_next  = cerr_reg;
		fail_next  = fail_reg;
		rie_next   = rie_reg;
		cnt_next   = cnt_reg;
		tmode_next = tmode_reg;
		tirq_next  = tirq_reg;
		irq_next   = 1'b0;
		vec_next   = vec_reg;
		eng_we     = 1'b0;
		eng_wa     = cur_reg;
		eng_wd     = 32'h00000000;
		case (state_reg)
			smcm_pkg::ST_RESET: begin
				chain_next = 1'b0;
				tmode_next = 1'b0;
				tirq_next  = 1'b0;
				if (cnt_reg == 8'h00) begin
					state_next = smcm_pkg::ST_POLL;
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			smcm_pkg::ST_POLL: begin
				if (!poll_word[smcm_pkg::CMD_DONE_BIT] && (poll_word != 16'h0000)) begin
					state_next = smcm_pkg::ST_EXEC;
					cur_next   = poll_idx;
					root_next  = poll_idx;
				end else begin
					chan_next = ~chan_reg;
				end
			end
			smcm_pkg::ST_EXEC: begin
				if (chain_reg && (cur_word == 32'h00000000)) begin
					state_next = smcm_pkg::ST_ROOT;
				end else if (dec_reset && dec_known) begin
					// no status return: the host watches the failure bit instead
					state_next = smcm_pkg::ST_RESET;
					cnt_next   = smcm_pkg::RESET_CYC;
				end else if (!chain_reg && dec_chain && dec_known) begin
					chain_next = 1'b1;
					rie_next   = dec_ie;
					cerr_next  = 1'b0;
					cur_next   = chan_reg ? smcm_pkg::CHAIN2_IDX : smcm_pkg::CHAIN1_IDX;
				end else begin
					// word 0 gets the status and the data at 2 is cleared; pointer at 4 and words 8..14 stay as the host left them
					eng_we = 1'b1;
					eng_wd = {16'h0000, smcm_pkg::mk_status(dec_ie, cmd_err ? smcm_pkg::ERR_INVALID
						: smcm_pkg::ERR_NONE)};
					if (!ahb_mem_wr) begin
						if (!cmd_err && dec_tmode) begin
							tmode_next = ~tmode_reg;
						end
						if (!cmd_err && dec_tirq) begin
							tirq_next = ~tirq_reg;
						end
						if (dec_ie && bi_ctl_reg[{chan_reg, cmd_err}][smcm_pkg::BI_EN_BIT]) begin
							irq_next = 1'b1;
							vec_next = bi_vec_reg[{chan_reg, cmd_err}];
						end
						if (chain_reg) begin
							cur_next = cur_reg + smcm_pkg::BLK_WORDS;
							if (cmd_err && !cerr_reg) begin
								cerr_next = 1'b1;
								fail_next = cur_reg;
							end
						end else begin
							state_next = smcm_pkg::ST_POLL;
							chan_next  = ~chan_reg;
						end
					end
				end
			end
			smcm_pkg::ST_ROOT: begin
				eng_we = 1'b1;
				eng_wa = root_reg;
				eng_wd = {16'h0000, smcm_pkg::mk_status(rie_reg, cerr_reg ? smcm_pkg::ERR_CHAIN
					: smcm_pkg::ERR_NONE)};
				if (!ahb_mem_wr) begin
					chain_next = 1'b0;
					if (cerr_reg) begin
						state_next = smcm_pkg::ST_ROOTPTR;
					end else begin
						state_next = smcm_pkg::ST_POLL;
						chan_next  = ~chan_reg;
						if (rie_reg && bi_ctl_reg[{chan_reg, 1'b0}][smcm_pkg::BI_EN_BIT]) begin
							irq_next = 1'b1;
							vec_next = bi_vec_reg[{chan_reg, 1'b0}];
						end
					end
				end
			end
			smcm_pkg::ST_ROOTPTR: begin
				eng_we = 1'b1;
				eng_wa = root_reg + 15'h0001;
				eng_wd = {15'h0000, fail_reg, 2'b00};
				if (!ahb_mem_wr) begin
					state_next = smcm_pkg::ST_POLL;
					chan_next  = ~chan_reg;
					if (rie_reg && bi_ctl_reg[{chan_reg, 1'b1}][smcm_pkg::BI_EN_BIT]) begin
						irq_next = 1'b1;
						vec_next = bi_vec_reg[{chan_reg, 1'b1}];
					end
				end
			end
			default: begin
				state_next = smcm_pkg::ST_RESET;
			end
		endcase
		// a target message shares the line; a completion in the same cycle wins
		if (!irq_next && tgt_irq) begin
			irq_next = 1'b1;
			vec_next = bi_vec_reg[0];
		end
		if (lrst_hit) begin
			state_next = smcm_pkg::ST_RESET;
			cnt_next   = smcm_pkg::RESET_CYC;
		end
	end

	always_ff @(posedge i_clk) begin
		if (mem_we) begin
			dpr_mem[mem_wa] <= mem_wd;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_reg <= smcm_pkg::ST_RESET;
			cnt_reg   <= smcm_pkg::RESET_CYC;
			chan_reg  <= 1'b0;
			cur_reg   <= 15'h0000;
			root_reg  <= 15'h0000;
			fail_reg  <= 15'h0000;
			chain_reg <= 1'b0;
			cerr_reg  <= 1'b0;
			rie_reg   <= 1'b0;
			tmode_reg <= 1'b0;
			tirq_reg  <= 1'b0;
			irq_reg   <= 1'b0;
			vec_reg   <= 8'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			chan_reg  <= chan_next;
			cur_reg   <= cur_next;
			root_reg  <= root_next;
			fail_reg  <= fail_next;
			chain_reg <= chain_next;
			cerr_reg  <= cerr_next;
			rie_reg   <= rie_next;
			tmode_reg <= tmode_next;
			tirq_reg  <= tirq_next;
			irq_reg   <= irq_next;
			vec_reg   <= vec_next;
		end
	end

	// reads take one wait state so that data never trails a write just before
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			dph_valid_reg <= 1'b0;
			dph_write_reg <= 1'b0;
			dph_addr_reg  <= 17'h00000;
			hready_reg    <= 1'b1;
			hrdata_reg    <= 32'h00000000;
		end else begin
			dph_valid_reg <= addr_acc;
			dph_write_reg <= i_hwrite;
			dph_addr_reg  <= i_haddr[16:0];
			hready_reg    <= !(addr_acc && !i_hwrite);
			if (rd_done) begin
				hrdata_reg <= rd_data;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			for (int i = 0; i < 4; i++) begin
				bi_ctl_reg[i] <= 8'h00;
				bi_vec_reg[i] <= 8'h00;
			end
		end else if (dph_wr && is_bictl) begin
			bi_ctl_reg[a[3:2]] <= i_hwdata[7:0];
		end else if (dph_wr && is_bivec) begin
			bi_vec_reg[a[3:2]] <= i_hwdata[7:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			tmsg_flag_reg <= 1'b0;
			tmsg_init_reg <= 3'h0;
			tmsg_ptr_reg  <= 32'h00000000;
			tmsg_blk_reg  <= 16'h0000;
			rst_src_reg   <= 1'b0;
			sysfail_reg   <= 1'b1;
		end else begin
			if (tmode_reg && i_tgt_msg_valid) begin
				tmsg_flag_reg <= 1'b1;
				tmsg_init_reg <= i_tgt_initiator;
				tmsg_ptr_reg  <= i_tgt_data_ptr;
				tmsg_blk_reg  <= i_tgt_blocks;
			end else if (dph_wr && is_tmsg0) begin
				tmsg_flag_reg <= 1'b0;
			end
			if (lrst_hit) begin
				rst_src_reg <= 1'b1;
			end else if (state_next != smcm_pkg::ST_RESET) begin
				rst_src_reg <= 1'b0;
			end
			sysfail_reg <= (state_next == smcm_pkg::ST_RESET);
		end
	end

	assign o_hrdata      = hrdata_reg;
	assign o_hreadyout   = hready_reg;
	assign o_hresp       = 1'b0;
	assign o_irq         = irq_reg;
	assign o_irq_vector  = vec_reg;
	assign o_sysfail     = sysfail_reg;
	assign o_target_mode = tmode_reg;

	chk_poll_pick: assert property (@(posedge i_clk) disable iff (i_srst)
		(state_reg == smcm_pkg::ST_POLL) && !poll_word[15] && (poll_word != 16'h0000) && !lrst_hit
		|=> (state_reg == smcm_pkg::ST_EXEC) && (cur_reg == root_reg))
		else $error("new command not taken from polled block");
	chk_status_flag: assert property (@(posedge i_clk) disable iff (i_srst)
		eng_ok && (state_reg == smcm_pkg::ST_EXEC) |=> dpr_mem[$past(eng_wa)][15])
		else $error("returned word lacks status flag");
	chk_irq_ie: assert property (@(posedge i_clk) disable iff (i_srst)
		eng_ok && (state_reg == smcm_pkg::ST_EXEC) && !dec_ie && !tgt_irq |=> !o_irq)
		else $error("interrupt without enable bit");
	chk_err_vector: assert property (@(posedge i_clk) disable iff (i_srst)
		eng_ok && (state_reg == smcm_pkg::ST_EXEC) && dec_ie && cmd_err && bi_ctl_reg[{chan_reg, 1'b1}][4]
		|=> o_irq && (o_irq_vector == $past(bi_vec_reg[{chan_reg, 1'b1}])))
		else $error("error completion used wrong vector");
	chk_bad_group: assert property (@(posedge i_clk) disable iff (i_srst)
		(state_reg == smcm_pkg::ST_EXEC) && eng_we && (cur_word[7:4] > 4'h6) && !chain_reg
		|-> eng_wd[11:0] == smcm_pkg::ERR_INVALID)
		else $error("reserved group not refused");
	chk_chain_end: assert property (@(posedge i_clk) disable iff (i_srst)
		(state_reg == smcm_pkg::ST_EXEC) && chain_reg && (cur_word == 32'h00000000) && !lrst_hit
		|=> (state_reg == smcm_pkg::ST_ROOT) ##[1:40] !chain_reg)
		else $error("chain end not handled");
	chk_root_ptr: assert property (@(posedge i_clk) disable iff (i_srst)
		(state_reg == smcm_pkg::ST_ROOT) && eng_ok && cerr_reg && !lrst_hit
		|=> (state_reg == smcm_pkg::ST_ROOTPTR) && (eng_wd[16:2] == fail_reg))
		else $error("failing block pointer not returned");
	chk_rev_read: assert property (@(posedge i_clk) disable iff (i_srst)
		addr_acc && !i_hwrite && (i_haddr[16:2] == smcm_pkg::REV_OFS[16:2])
		|-> ##1 !o_hreadyout ##1 o_hreadyout && (o_hrdata[15:0] == REVISION))
		else $error("revision word not returned");
	chk_tmsg_neg: assert property (@(posedge i_clk) disable iff (i_srst)
		tmode_reg && i_tgt_msg_valid |=> tmsg_flag_reg && (tmsg_blk_reg == $past(i_tgt_blocks)))
		else $error("target message not recorded");
	chk_local_rst: assert property (@(posedge i_clk) disable iff (i_srst)
		lrst_hit |=> (state_reg == smcm_pkg::ST_RESET) && o_sysfail && rst_src_reg)
		else $error("reset window did not reset controller");
endmodule

// ---- test/smcm_host.sv ----
`timescale 1ns/1ps
module smcm_host (
	input  wire logic        i_clk,
	input  wire logic        i_hready,
	input  wire logic [31:0] i_hrdata,
	output logic             o_hsel,
	output logic      [31:0] o_haddr,
	output logic      [1:0]  o_htrans,
	output logic             o_hwrite,
	output logic      [2:0]  o_hsize,
	output logic      [31:0] o_hwdata
);
	bit hang = 1'b0;
	initial begin
		o_hsel = 1'b1;
		o_haddr = 32'h0;
		o_htrans = 2'h0;
		o_hwrite = 1'b0;
		o_hsize = 3'h2;
		o_hwdata = 32'h0;
	end
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_hready !== 1'b1 && n < 64);
		if (n >= 64) hang = 1'b1;
	endtask
	// one whole-word single transfer; nothing moves before hready is seen high
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clk);
		o_haddr <= a;
		o_hwrite <= w;
		o_htrans <= 2'h2;
		wait_rdy();
		o_htrans <= 2'h0;
		// on reads the data lines flip to their inverse, so back-to-back reads alternate between the last write and its inverse
		o_hwdata <= w ? d : ~o_hwdata;
		wait_rdy();
		q = i_hrdata;
	endtask
endmodule

// ---- test/shared_memory_command_mailbox_tb.sv ----
`timescale 1ns/1ps
module shared_memory_command_mailbox_tb;
	localparam logic [15:0] REV = 16'h0c3a; // arbitrary value
	logic        i_clk = 1'b0;
	logic        i_srst = 1'b1;
	logic        tgt_v = 1'b0;
	logic        hsel, hwrite, hready, hresp, irq, sysfail, tmode;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  vec;
	logic [31:0] haddr, hwdata, hrdata, q;
	int          err_count = 0;
	int          check_count = 0;
	int          irq_n = 0;
	logic [31:0] rows [0:36] = '{32'h0003_8000, 32'h000a_8000, 32'h000b_8000, 32'h000c_8000, 32'h000d_8000,
		32'h000e_8000, 32'h0010_8000, 32'h0014_8000, 32'h0020_8000, 32'h0022_8000, 32'h0030_8000, 32'h0032_8000,
		32'h0033_8000, 32'h0035_8000, 32'h0044_8000, 32'h0045_8000, 32'h0046_8000, 32'h0050_8000, 32'h0055_8000,
		32'h0056_8000, 32'h0057_8000, 32'h0058_8000, 32'h0059_8000, 32'h005a_8000, 32'h005b_8000, 32'h005c_8000,
		32'h005e_8000, 32'h0060_8000, 32'h0063_8000, 32'h0061_8000, 32'h0e20_8000, 32'h0110_8000, 32'h0070_8006,
		32'h00f0_8006, 32'h1010_9000, 32'h0b44_8000, 32'h6046_8000};
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) if (irq === 1'b1) irq_n <= irq_n + 1;
	smcm_host i_host (.i_clk(i_clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
		.o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
	smcm_mailbox #(.REVISION(REV)) i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_tgt_msg_valid(tgt_v),
		.i_tgt_initiator(3'h5), .i_tgt_data_ptr(32'h0000_2300), .i_tgt_blocks(16'h0007), .o_irq(irq),
		.o_irq_vector(vec), .o_sysfail(sysfail), .o_target_mode(tmode));
	task automatic conclude();
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rw(input logic w, input logic [31:0] a, input logic [31:0] d);
		i_host.xfer(w, a, d, q);
		if (i_host.hang) begin
			err_count++;
			conclude();
		end
	endtask
	// parameters first, command word last, then poll until the done flag shows
	task automatic run(input logic [31:0] a, input logic [15:0] c, input logic [15:0] st);
		int n;
		rw(1'b1, a + 32'h8, 32'h5a5a_a5a5);
		rw(1'b1, a + 32'hc, 32'h0f0f_0001);
		rw(1'b1, a, {16'h1234, c});
		n = 0;
		do begin
			rw(1'b0, a, 32'h0);
			n++;
		end while (q[15] !== 1'b1 && n < 60);
		if (n >= 60) begin
			err_count++;
			conclude();
		end
		chk(q, {16'h0, st});
		rw(1'b0, a + 32'h8, 32'h0);
		chk(q, 32'h5a5a_a5a5);
		rw(1'b0, a + 32'hc, 32'h0);
		chk(q, 32'h0f0f_0001);
	endtask
	initial begin
		repeat (6) @(posedge i_clk);
		chk({29'h0, sysfail, irq, tmode}, 32'h4);
		i_srst <= 1'b0;
		rw(1'b1, 32'h2100, 32'h0);
		rw(1'b1, 32'h3500, 32'h0);
		rw(1'b0, 32'h0, 32'h0);
		chk({31'h0, q[9]}, 32'h1);
		repeat (110) @(posedge i_clk);
		rw(1'b0, 32'h0, 32'h0);
		chk({31'h0, q[9]}, 32'h0);
		rw(1'b1, 32'h2000, 32'hffff_ffff);
		rw(1'b0, 32'h2000, 32'h0);
		chk({16'h0, q[15:0]}, {16'h0, REV});
		for (int i = 0; i < 37; i++)
			run(i[0] ? 32'h3500 : 32'h2100, rows[i][31:16], rows[i][15:0]);
		chk({31'h0, tmode}, 32'h1);
		chk(32'(irq_n), 32'h0);
		@(posedge i_clk);
		tgt_v <= 1'b1;
		@(posedge i_clk);
		tgt_v <= 1'b0;
		rw(1'b0, 32'h20f0, 32'h0);
		chk(q, 32'h0005_8000);
		rw(1'b0, 32'h20f8, 32'h0);
		chk({16'h0, q[15:0]}, 32'h7);
		rw(1'b0, 32'h20f4, 32'h0);
		chk(q, 32'h0000_2300);
		rw(1'b1, 32'h20f0, 32'h0);
		rw(1'b0, 32'h20f0, 32'h0);
		chk(q, 32'h0005_0000);
		rw(1'b1, 32'h10, 32'h10);
		rw(1'b1, 32'h20, 32'h40);
		rw(1'b1, 32'h14, 32'h10);
		rw(1'b1, 32'h24, 32'h41);
		run(32'h2100, 16'h1003, 16'h9000);
		repeat (3) @(posedge i_clk);
		chk({16'h0, 8'(irq_n), vec}, 32'h0140);
		run(32'h2100, 16'h1070, 16'h9006);
		repeat (3) @(posedge i_clk);
		chk({16'h0, 8'(irq_n), vec}, 32'h0241);
		// chain of a good block, a failing block and the zero terminator
		rw(1'b1, 32'h2110, 32'h1010);
		rw(1'b1, 32'h2120, 32'h1070);
		rw(1'b1, 32'h2130, 32'h0);
		run(32'h2100, 16'h105d, 16'h9010);
		chk({16'h0, 8'(irq_n), vec}, 32'h0541);
		rw(1'b0, 32'h2104, 32'h0);
		chk(q, 32'h2120);
		rw(1'b0, 32'h2110, 32'h0);
		chk({16'h0, q[15:0]}, 32'h9000);
		rw(1'b0, 32'h2120, 32'h0);
		chk({16'h0, q[15:0]}, 32'h9006);
		run(32'h3500, 16'h0044, 16'h8000);
		// firmware reset leaves no status: clear the word while the controller is held
		rw(1'b1, 32'h3500, 32'h0000_0009);
		repeat (8) @(posedge i_clk);
		chk({30'h0, sysfail, tmode}, 32'h2);
		rw(1'b1, 32'h3500, 32'h0);
		repeat (110) @(posedge i_clk);
		chk({31'h0, sysfail}, 32'h0);
		rw(1'b1, 32'h1804, 32'h0);
		@(posedge i_clk);
		chk({31'h0, sysfail}, 32'h1);
		rw(1'b0, 32'h0, 32'h0);
		chk({29'h0, q[10:8]}, 32'h7);
		chk({31'h0, hresp}, 32'h0);
		conclude();
	end
endmodule
